//--- dppt_pkg.sv
// Contract
// - Slot index 0..197, or 0..97 small variant.
// - Three slots: ON, OFF, limit counts.
// - Enable on: count ON time, output high.
// - Then count OFF time, output low, repeat.
// - Enable off holds output low always.
// - Enable off clears elapsed counters.
// - Presets are unsigned 16-bit, software written.
// - Endless mode repeats while enable stays on.
// - Pulse-count mode stops after limit pulses.
// - Total-time mode stops after limit time.
// - Endless mode ignores the limit preset.
// - Ticks of 1 s, 100 ms, 10 ms, 1 ms.
// - Preset changes act immediately.
// - Raised ON preset extends current ON period.
// - ON preset at/below count ends ON now.
// - Raised OFF preset extends current OFF period.
// - OFF preset at/below count starts ON now.
// - Reset reloads presets from stored defaults.
package dppt_pkg;
  // Clock and time base figures; cycle counts derive from them.
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NS_PER_MS = 1_000_000;
  localparam int unsigned T_1S_MS = 1000;
  localparam int unsigned T_100MS_MS = 100;
  localparam int unsigned T_10MS_MS = 10;
  localparam int unsigned T_1MS_MS = 1;
  localparam int unsigned CYC_1S = T_1S_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned CYC_100MS = T_100MS_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned CYC_10MS = T_10MS_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned CYC_1MS = T_1MS_MS * NS_PER_MS / CLK_PERIOD_NS;
  // Slot pool limits and the slot footprint of this block.
  localparam int unsigned SLOT_MAX_FULL = 197;
  localparam int unsigned SLOT_MAX_SMALL = 97;
  localparam int unsigned SLOTS_USED = 3;
  // Preset width.
  localparam int unsigned PRESET_W = 16;
  // Byte offsets of the register map.
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_ON = 6'h04;
  localparam logic [5:0] ADDR_OFF = 6'h08;
  localparam logic [5:0] ADDR_LIM = 6'h0C;
  localparam logic [5:0] ADDR_STAT = 6'h10;
  localparam logic [5:0] ADDR_ELAP0 = 6'h14;
  localparam logic [5:0] ADDR_ELAP1 = 6'h18;
  localparam logic [5:0] ADDR_ELAP2 = 6'h1C;
  localparam logic [5:0] ADDR_SLOT = 6'h20;
  // Control fields.
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SCALE_LSB = 2;
  // Status bit positions.
  localparam int unsigned STAT_OUT = 0;
  localparam int unsigned STAT_EN = 1;
  localparam int unsigned STAT_DONE = 2;
  localparam int unsigned STAT_ON = 3;
  // Run modes.
  localparam logic [1:0] MODE_ENDLESS = 2'h0;
  localparam logic [1:0] MODE_COUNT = 2'h1;
  localparam logic [1:0] MODE_TIME = 2'h2;
  // Time base selections.
  localparam logic [1:0] SCALE_1S = 2'h0;
  localparam logic [1:0] SCALE_100MS = 2'h1;
  localparam logic [1:0] SCALE_10MS = 2'h2;
  localparam logic [1:0] SCALE_1MS = 2'h3;
  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF, ST_DONE} dppt_state_t;
endpackage : dppt_pkg

//--- dppt_slot_cnt.sv
`timescale 1ns/1ns
// One elapsed-time slot: clears, steps by one, saturates at all ones.
module dppt_slot_cnt #(
  parameter int unsigned W = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Control.
  input wire logic clr,
  input wire logic inc,
  // Elapsed value.
  output logic [W-1:0] count
);
  // All state of the slot.
  typedef struct packed {
    logic [W-1:0] cnt;
  } dppt_cnt_t;
  dppt_cnt_t s_q;
  dppt_cnt_t s_d;

  // Saturation keeps a long run from wrapping back under a preset.
  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.cnt = '0;
    end else if (inc && (s_q.cnt != '1)) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;

  // A step never skips a value.
  AST_CNT_STEP: assert property (@(posedge mclk) disable iff (!nrst)
    (!clr && inc && count != '1) |=> (count == $past(count) + 1'b1))
    else $error("slot counter did not step by one");
endmodule : dppt_slot_cnt

//--- dppt_prescale.sv
`timescale 1ns/1ns
// Divides mclk down to one tick per selected time base unit.
module dppt_prescale #(
  parameter int unsigned CYC_1S = dppt_pkg::CYC_1S,
  parameter int unsigned CYC_100MS = dppt_pkg::CYC_100MS,
  parameter int unsigned CYC_10MS = dppt_pkg::CYC_10MS,
  parameter int unsigned CYC_1MS = dppt_pkg::CYC_1MS,
  parameter int unsigned CW = 24
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Restart and time base select.
  input wire logic clr,
  input wire logic [1:0] scale,
  // One-cycle tick.
  output logic tick
);
  // All state of the divider.
  typedef struct packed {
    logic [CW-1:0] cnt;
  } dppt_pre_t;
  dppt_pre_t s_q;
  dppt_pre_t s_d;
  logic [CW-1:0] reload;

  if (CYC_1MS < 2 || CYC_1S >= (64'h1 << CW)) begin : g_chk
    $error("prescaler periods do not fit the counter");
  end

  // Reload value for the chosen base; a change applies at the next reload.
  always_comb begin
    case (scale)
      dppt_pkg::SCALE_1S: reload = CW'(CYC_1S - 1);
      dppt_pkg::SCALE_100MS: reload = CW'(CYC_100MS - 1);
      dppt_pkg::SCALE_10MS: reload = CW'(CYC_10MS - 1);
      default: reload = CW'(CYC_1MS - 1);
    endcase
  end

  // Count down; the tick marks the zero crossing.
  always_comb begin
    s_d = s_q;
    if (clr || s_q.cnt == '0) begin
      s_d.cnt = reload;
    end else begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Held off during restart so the first unit after enable is whole.
  assign tick = !clr && (s_q.cnt == '0);

  // Two ticks are never adjacent since every base spans many cycles.
  AST_TICK_GAP: assert property (@(posedge mclk) disable iff (!nrst)
    tick |=> !tick)
    else $error("prescaler ticked on consecutive cycles");
endmodule : dppt_prescale

//--- dppt_dual_period_block.sv
`timescale 1ns/1ns
// Repeating ON/OFF pulse generator with endless, pulse-count and
// total-time run modes, presets reachable over Avalon-MM.
module dppt_dual_period_block #(
  parameter int unsigned SLOT_BASE = 0,
  parameter bit SMALL_VARIANT = 1'b0,
  parameter logic [15:0] ON_DEFAULT = 16'h0001,
  parameter logic [15:0] OFF_DEFAULT = 16'h0001,
  parameter logic [15:0] LIM_DEFAULT = 16'h0000,
  parameter logic [1:0] MODE_DEFAULT = dppt_pkg::MODE_ENDLESS,
  parameter logic [1:0] SCALE_DEFAULT = dppt_pkg::SCALE_1S,
  parameter int unsigned CYC_1S = dppt_pkg::CYC_1S,
  parameter int unsigned CYC_100MS = dppt_pkg::CYC_100MS,
  parameter int unsigned CYC_10MS = dppt_pkg::CYC_10MS,
  parameter int unsigned CYC_1MS = dppt_pkg::CYC_1MS
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Enable from program logic on the same clock, and the pulse output.
  input wire logic en,
  output logic pulse_out,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int unsigned PW = dppt_pkg::PRESET_W;

  // All state of the block: sequencer, bus answer and working presets.
  typedef struct packed {
    dppt_pkg::dppt_state_t st;
    logic out;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] mode;
    logic [1:0] scale;
    logic [PW-1:0] on_dur;
    logic [PW-1:0] off_dur;
    logic [PW-1:0] lim_val;
  } dppt_core_t;

  dppt_core_t s_q;
  dppt_core_t s_d;

  // Elapsed counters, one per occupied slot: ON, OFF, limit.
  logic [PW-1:0] elap [dppt_pkg::SLOTS_USED];
  logic [dppt_pkg::SLOTS_USED-1:0] c_clr;
  logic [dppt_pkg::SLOTS_USED-1:0] c_inc;
  logic tick;
  logic lim_hit;
  logic req;
  logic wr_go;

  // Slot index must not exceed the pool maximum; only SLOT_BASE itself is checked.
  // The small variant has a shorter pool; a bad index fails at build.
  if (SLOT_BASE > (SMALL_VARIANT ? dppt_pkg::SLOT_MAX_SMALL
                                 : dppt_pkg::SLOT_MAX_FULL)) begin : g_slot_chk
    $error("slot index out of range for this variant");
  end

  // The three slots sit at consecutive indices from SLOT_BASE.
  for (genvar i = 0; i < dppt_pkg::SLOTS_USED; i++) begin : g_slot
    dppt_slot_cnt #(
      .W(PW)
    ) i_dppt_slot_cnt (
      .mclk(mclk),
      .nrst(nrst),
      .clr(c_clr[i]),
      .inc(c_inc[i]),
      .count(elap[i])
    );
  end

  // Time base restarts while idle so the first ON unit is a full one.
  dppt_prescale #(
    .CYC_1S(CYC_1S),
    .CYC_100MS(CYC_100MS),
    .CYC_10MS(CYC_10MS),
    .CYC_1MS(CYC_1MS)
  ) i_dppt_prescale (
    .mclk(mclk),
    .nrst(nrst),
    .clr(s_q.st == dppt_pkg::ST_IDLE),
    .scale(s_q.scale),
    .tick(tick)
  );

  // Bus request and the edge at which a write takes effect.
  assign req = avs_read || avs_write;
  assign wr_go = avs_write && s_q.ack;

  // Limit reached; never in endless mode, which ignores the limit.
  assign lim_hit = (s_q.mode != dppt_pkg::MODE_ENDLESS) &&
                   (elap[2] >= s_q.lim_val);

  // Sequencer. Presets are compared live each cycle, so a rewritten
  // preset acts on the very next cycle without waiting for a period end.
  always_comb begin
    s_d = s_q;
    c_clr = '0;
    c_inc = '0;
    if (!en) begin
      // Disabled: the state and elapsed counters return to zero and the output falls.
      s_d.st = dppt_pkg::ST_IDLE;
      c_clr = '1;
    end else begin
      case (s_q.st)
        dppt_pkg::ST_IDLE: begin
          // A zero limit ends the run before any pulse.
          if (lim_hit) begin
            s_d.st = dppt_pkg::ST_DONE;
          end else begin
            s_d.st = dppt_pkg::ST_ON;
          end
        end
        dppt_pkg::ST_ON: begin
          // ON phase: count ticks against the live ON preset.
          c_inc[2] = tick && (s_q.mode == dppt_pkg::MODE_TIME);
          if (lim_hit) begin
            s_d.st = dppt_pkg::ST_DONE;
          end else if (elap[0] >= s_q.on_dur) begin
            // Also taken at once when ON is lowered under the count.
            s_d.st = dppt_pkg::ST_OFF;
            c_clr[0] = 1'b1;
            c_inc[2] = (s_q.mode == dppt_pkg::MODE_COUNT) ||
                       (tick && (s_q.mode == dppt_pkg::MODE_TIME));
          end else begin
            c_inc[0] = tick;
          end
        end
        dppt_pkg::ST_OFF: begin
          // OFF phase: the time limit keeps counting here too.
          c_inc[2] = tick && (s_q.mode == dppt_pkg::MODE_TIME);
          if (lim_hit) begin
            s_d.st = dppt_pkg::ST_DONE;
          end else if (elap[1] >= s_q.off_dur) begin
            // Endless mode comes back here every cycle of the pattern.
            s_d.st = dppt_pkg::ST_ON;
            c_clr[1] = 1'b1;
          end else begin
            c_inc[1] = tick;
          end
        end
        dppt_pkg::ST_DONE: begin
          // Parked until enable drops; only that restarts from zero.
          s_d.st = dppt_pkg::ST_DONE;
        end
        default: begin
          s_d.st = dppt_pkg::ST_IDLE;
        end
      endcase
    end
    // Output is high exactly in the ON phase.
    s_d.out = (s_d.st == dppt_pkg::ST_ON);

    // Bus: one wait cycle, read data captured in the first cycle.
    s_d.ack = req && !s_q.ack;
    if (req && !s_q.ack) begin
      case (avs_address)
        dppt_pkg::ADDR_CTRL: begin
          s_d.rdata = '0;
          s_d.rdata[dppt_pkg::CTRL_MODE_LSB +: 2] = s_q.mode;
          s_d.rdata[dppt_pkg::CTRL_SCALE_LSB +: 2] = s_q.scale;
        end
        dppt_pkg::ADDR_ON: s_d.rdata = 32'(s_q.on_dur);
        dppt_pkg::ADDR_OFF: s_d.rdata = 32'(s_q.off_dur);
        dppt_pkg::ADDR_LIM: s_d.rdata = 32'(s_q.lim_val);
        dppt_pkg::ADDR_STAT: begin
          s_d.rdata = '0;
          s_d.rdata[dppt_pkg::STAT_OUT] = s_q.out;
          s_d.rdata[dppt_pkg::STAT_EN] = en;
          s_d.rdata[dppt_pkg::STAT_DONE] = (s_q.st == dppt_pkg::ST_DONE);
          s_d.rdata[dppt_pkg::STAT_ON] = (s_q.st == dppt_pkg::ST_ON);
        end
        dppt_pkg::ADDR_ELAP0: s_d.rdata = 32'(elap[0]);
        dppt_pkg::ADDR_ELAP1: s_d.rdata = 32'(elap[1]);
        dppt_pkg::ADDR_ELAP2: s_d.rdata = 32'(elap[2]);
        dppt_pkg::ADDR_SLOT: s_d.rdata = 32'(SLOT_BASE);
        default: s_d.rdata = '0;
      endcase
    end

    // Writes land in volatile working copies; byte lanes 0 and 1 only.
    // Lanes 2 and 3 carry nothing, since the presets are 16 bits wide.
    if (wr_go) begin
      case (avs_address)
        dppt_pkg::ADDR_CTRL: begin
          if (avs_byteenable[0]) begin
            s_d.mode = avs_writedata[dppt_pkg::CTRL_MODE_LSB +: 2];
            s_d.scale = avs_writedata[dppt_pkg::CTRL_SCALE_LSB +: 2];
          end
        end
        dppt_pkg::ADDR_ON: begin
          if (avs_byteenable[0]) s_d.on_dur[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) s_d.on_dur[15:8] = avs_writedata[15:8];
        end
        dppt_pkg::ADDR_OFF: begin
          if (avs_byteenable[0]) s_d.off_dur[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) s_d.off_dur[15:8] = avs_writedata[15:8];
        end
        dppt_pkg::ADDR_LIM: begin
          if (avs_byteenable[0]) s_d.lim_val[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) s_d.lim_val[15:8] = avs_writedata[15:8];
        end
        default: begin
          // Read-only and unmapped words ignore writes.
        end
      endcase
    end
  end

  // State register; reset restores the stored preset image.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q.st <= dppt_pkg::ST_IDLE;
      s_q.out <= 1'b0;
      s_q.ack <= 1'b0;
      s_q.rdata <= '0;
      s_q.mode <= MODE_DEFAULT;
      s_q.scale <= SCALE_DEFAULT;
      s_q.on_dur <= ON_DEFAULT;
      s_q.off_dur <= OFF_DEFAULT;
      s_q.lim_val <= LIM_DEFAULT;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs; the handshake is combinational, data come from flops.
  assign pulse_out = s_q.out;
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = req && !s_q.ack;

  // Enable low forces the output low on the next edge.
  AST_EN_LOW_OUT: assert property (@(posedge mclk) disable iff (!nrst)
    !en |=> !pulse_out)
    else $error("output high after enable was low");

  // Enable low empties the ON, OFF and limit slots.
  AST_EN_LOW_CLR: assert property (@(posedge mclk) disable iff (!nrst)
    !en |=> (elap[0] == '0 && elap[1] == '0 && elap[2] == '0))
    else $error("elapsed counters not cleared while disabled");

  // Enable in endless mode from idle raises the output next edge.
  AST_START_ON: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.st == dppt_pkg::ST_IDLE && en &&
     s_q.mode == dppt_pkg::MODE_ENDLESS) |=> pulse_out)
    else $error("output did not rise on enable");

  // ON count at or past the preset ends the ON phase at once.
  AST_ON_END: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.st == dppt_pkg::ST_ON && en && !lim_hit &&
     elap[0] >= s_q.on_dur) |=> !pulse_out && elap[0] == '0)
    else $error("ON phase did not end at its preset");

  // OFF count at or past the preset starts the ON phase in endless mode.
  AST_OFF_END: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.st == dppt_pkg::ST_OFF && en && elap[1] >= s_q.off_dur &&
     s_q.mode == dppt_pkg::MODE_ENDLESS) |=> pulse_out && elap[1] == '0)
    else $error("ON phase did not restart after OFF");

  // Endless mode never parks, whatever the limit says.
  AST_ENDLESS: assert property (@(posedge mclk) disable iff (!nrst)
    (en && s_q.mode == dppt_pkg::MODE_ENDLESS &&
     s_q.st != dppt_pkg::ST_DONE) |=> s_q.st != dppt_pkg::ST_DONE)
    else $error("endless mode stopped");

  // Reaching the limit in a limited mode drops the output for good.
  AST_LIMIT_STOP: assert property (@(posedge mclk) disable iff (!nrst)
    (en && lim_hit && s_q.st != dppt_pkg::ST_DONE)
    |=> !pulse_out && s_q.st == dppt_pkg::ST_DONE)
    else $error("limit reached but output kept running");

  // Parked state keeps the output low while enable stays on.
  AST_PARKED: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.st == dppt_pkg::ST_DONE && en) |=> !pulse_out)
    else $error("parked block raised its output");

  // ON count holds between ticks below the preset.
  AST_ON_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.st == dppt_pkg::ST_ON && en && !tick && !lim_hit &&
     elap[0] < s_q.on_dur) |=> $stable(elap[0]))
    else $error("ON count moved without a tick");

  // OFF count holds between ticks below the preset.
  AST_OFF_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.st == dppt_pkg::ST_OFF && en && !tick && !lim_hit &&
     elap[1] < s_q.off_dur) |=> $stable(elap[1]))
    else $error("OFF count moved without a tick");

  // Leaving idle below the limit starts a fresh ON phase.
  AST_IDLE_START: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.st == dppt_pkg::ST_IDLE && en && !lim_hit)
    |=> s_q.st == dppt_pkg::ST_ON && elap[0] == '0)
    else $error("run did not start from zero");

  // Pulse-count mode steps the limit slot at each ON end.
  AST_COUNT_STEP: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.st == dppt_pkg::ST_ON && en && !lim_hit &&
     elap[0] >= s_q.on_dur && elap[2] != '1 &&
     s_q.mode == dppt_pkg::MODE_COUNT)
    |=> elap[2] == $past(elap[2]) + 1'b1)
    else $error("pulse count did not step");

  // Total-time mode steps the limit slot on every tick of the ON and OFF phases.
  AST_TIME_STEP: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.st != dppt_pkg::ST_IDLE && s_q.st != dppt_pkg::ST_DONE &&
     en && tick && !lim_hit && elap[2] != '1 &&
     s_q.mode == dppt_pkg::MODE_TIME)
    |=> elap[2] == $past(elap[2]) + 1'b1)
    else $error("total time did not step");

  // Endless mode leaves the limit slot alone.
  AST_NO_LIMIT: assert property (@(posedge mclk) disable iff (!nrst)
    (en && s_q.mode == dppt_pkg::MODE_ENDLESS)
    |=> $stable(elap[2]))
    else $error("limit slot moved in endless mode");

  // Every request is answered after exactly one wait cycle.
  AST_ONE_WAIT: assert property (@(posedge mclk) disable iff (!nrst)
    (req && !s_q.ack) |=> s_q.ack)
    else $error("bus request was not answered");

  // A full-width write lands on the ON preset at once.
  AST_ON_WRITE: assert property (@(posedge mclk) disable iff (!nrst)
    (wr_go && avs_address == dppt_pkg::ADDR_ON &&
     avs_byteenable[1:0] == 2'h3)
    |=> s_q.on_dur == $past(avs_writedata[15:0]))
    else $error("ON preset write did not land");

  // A full-width write lands on the OFF preset at once.
  AST_OFF_WRITE: assert property (@(posedge mclk) disable iff (!nrst)
    (wr_go && avs_address == dppt_pkg::ADDR_OFF &&
     avs_byteenable[1:0] == 2'h3)
    |=> s_q.off_dur == $past(avs_writedata[15:0]))
    else $error("OFF preset write did not land");

  // A parked block stays parked until enable drops.
  AST_PARK_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.st == dppt_pkg::ST_DONE && en)
    |=> s_q.st == dppt_pkg::ST_DONE)
    else $error("parked block left the parked state");
endmodule : dppt_dual_period_block

//--- dppt_prog_model.sv
`timescale 1ns/1ns
// Program logic that drives the run enable; it answers promptly or late.
module dppt_prog_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic nrst,
  // Run request and lateness select from the bench.
  input wire logic run,
  input wire logic slow,
  // Run enable towards the block.
  output logic en
);
  logic [2:0] dly_q; // Cycles the request has waited.
  // A late controller raises the enable four cycles later; release is never late.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dly_q <= 3'h0;
      en <= 1'b0;
    end else if (!run) begin
      dly_q <= 3'h0;
      en <= 1'b0;
    end else if (!slow || dly_q == 3'h4) begin
      en <= 1'b1;
    end else begin
      dly_q <= dly_q + 3'h1;
    end
  end
endmodule : dppt_prog_model

//--- tb_dppt_dual_period_block.sv
`timescale 1ns/1ns
// Self-checking bench for the dual period pulse block.
module tb_dppt_dual_period_block;
  localparam int unsigned CYCS [4] = '{8, 6, 4, 3}; // Shortened cycles per tick.
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic run = 1'b0; // Run request to the program model.
  logic slow = 1'b0; // Late enable select.
  logic en;
  logic pulse_out;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int fails = 0;
  int n_compared = 0;
  // Slot base 5 is free of any other timer user.
  dppt_dual_period_block #(.SLOT_BASE(5), .ON_DEFAULT(16'h0003), .OFF_DEFAULT(16'h0002),
    .CYC_1S(CYCS[0]), .CYC_100MS(CYCS[1]), .CYC_10MS(CYCS[2]), .CYC_1MS(CYCS[3])
  ) i_dppt_dual_period_block (.mclk(mclk), .nrst(nrst), .en(en), .pulse_out(pulse_out),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  dppt_prog_model i_dppt_prog_model (.mclk(mclk), .nrst(nrst), .run(run), .slow(slow),
    .en(en));
  // Clock at 10 MHz.
  always #50 mclk = ~mclk;
  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  // One bus cycle; the request holds until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask : rd
  task automatic set_run(input logic v);
    @(posedge mclk);
    run <= v;
  endtask : set_run
  // Counts samples while the output stays at one level.
  task automatic meas(input logic lvl, output int n);
    n = 0;
    while (pulse_out === lvl) begin
      n++;
      @(negedge mclk);
    end
  endtask : meas
  // Counts samples until the output reaches a level; the watchdog bounds it.
  task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (pulse_out !== lvl);
  endtask : wait_lvl
  // Counts rising edges and the last high sample over a window.
  task automatic watch(input int cyc, output int r, output int last);
    logic prev;
    prev = pulse_out;
    r = 0;
    last = 0;
    for (int i = 1; i <= cyc; i++) begin
      @(negedge mclk);
      if (pulse_out === 1'b1 && prev !== 1'b1) r++;
      if (pulse_out === 1'b1) last = i;
      prev = pulse_out;
    end
  endtask : watch
  // A phase of p ticks may start mid-tick, so it spans one tick of slack.
  function automatic bit ok_len(int n, int p, int c);
    return n > p * c - c && n <= p * c + 2;
  endfunction : ok_len
  task automatic t_reset;
    logic [31:0] q;
    rd(dppt_pkg::ADDR_CTRL, q);
    check(q, 32'h0000_0000, "ctrl");
    rd(dppt_pkg::ADDR_ON, q);
    check(q, 32'h0000_0003, "on preset");
    rd(dppt_pkg::ADDR_SLOT, q);
    check(q, 32'h0000_0005, "slot");
    wr(dppt_pkg::ADDR_ELAP1, 32'h0000_FFFF);
    rd(dppt_pkg::ADDR_ELAP1, q);
    check(q, 32'h0000_0000, "elapsed");
    wr(6'h24, 32'h0000_FFFF);
    rd(6'h24, q);
    check(q, 32'h0000_0000, "unmapped");
    wr(dppt_pkg::ADDR_LIM, 32'hFFFF_FFFF);
    rd(dppt_pkg::ADDR_LIM, q);
    check(q, 32'h0000_FFFF, "limit");
    $display("done reset");
  endtask : t_reset
  // ON and OFF of two ticks at one scale, then a drop of enable in ON.
  task automatic t_endless(input logic [1:0] s);
    logic [31:0] q;
    int n;
    slow <= s[0];
    wr(dppt_pkg::ADDR_ON, 32'h0000_0002);
    wr(dppt_pkg::ADDR_OFF, 32'h0000_0002);
    wr(dppt_pkg::ADDR_CTRL, {28'h0, s, dppt_pkg::MODE_ENDLESS});
    set_run(1'b1);
    wait_lvl(1'b1, n);
    check(32'(n <= 8), 32'h1, "rise");
    for (int k = 0; k < 2; k++) begin
      meas(1'b1, n);
      check(32'(ok_len(n, 2, CYCS[s])), 32'h1, "on len");
      meas(1'b0, n);
      check(32'(ok_len(n, 2, CYCS[s])), 32'h1, "off len");
    end
    set_run(1'b0);
    wait_lvl(1'b0, n);
    check(32'(n <= 3), 32'h1, "drop");
    rd(dppt_pkg::ADDR_ELAP0, q);
    check(q, 32'h0000_0000, "elapsed on");
    $display("done endless");
  endtask : t_endless
  // Pulse count and total time limits at the 1 ms scale.
  task automatic t_limit;
    logic [31:0] q;
    int r;
    int last;
    wr(dppt_pkg::ADDR_ON, 32'h0000_0001);
    wr(dppt_pkg::ADDR_OFF, 32'h0000_0001);
    wr(dppt_pkg::ADDR_LIM, 32'h0000_0003);
    wr(dppt_pkg::ADDR_CTRL, {28'h0, dppt_pkg::SCALE_1MS, dppt_pkg::MODE_COUNT});
    for (int k = 0; k < 2; k++) begin
      set_run(1'b1);
      watch(80, r, last);
      check(32'(r), 32'h3, "pulses");
      rd(dppt_pkg::ADDR_STAT, q);
      check(q[dppt_pkg::STAT_DONE], 32'h1, "done");
      check(32'(q[3:0]), 32'h0000_0006, "status");
      set_run(1'b0);
      repeat (3) @(posedge mclk);
    end
    wr(dppt_pkg::ADDR_LIM, 32'h0000_0000);
    set_run(1'b1);
    watch(40, r, last);
    check(32'(r), 32'h0, "zero limit");
    set_run(1'b0);
    wr(dppt_pkg::ADDR_CTRL, {28'h0, dppt_pkg::SCALE_1MS, dppt_pkg::MODE_ENDLESS});
    set_run(1'b1);
    watch(60, r, last);
    check(32'(r >= 4), 32'h1, "endless");
    set_run(1'b0);
    wr(dppt_pkg::ADDR_LIM, 32'h0000_0006);
    wr(dppt_pkg::ADDR_CTRL, {28'h0, dppt_pkg::SCALE_1MS, dppt_pkg::MODE_TIME});
    set_run(1'b1);
    watch(80, r, last);
    check(32'(r >= 2 && last > 10 && last <= 24), 32'h1, "total time");
    set_run(1'b0);
    $display("done limit");
  endtask : t_limit
  // Presets rewritten in mid-phase at the 1 ms scale.
  task automatic t_change;
    logic [31:0] q;
    int n;
    wr(dppt_pkg::ADDR_ON, 32'h0000_0014);
    wr(dppt_pkg::ADDR_OFF, 32'h0000_0014);
    wr(dppt_pkg::ADDR_CTRL, {28'h0, dppt_pkg::SCALE_1MS, dppt_pkg::MODE_ENDLESS});
    set_run(1'b1);
    wait_lvl(1'b1, n);
    repeat (15) @(negedge mclk);
    rd(dppt_pkg::ADDR_ELAP0, q);
    check(32'(q > 0 && q < 20), 32'h1, "on count");
    wr(dppt_pkg::ADDR_ON, 32'h0000_001E);
    meas(1'b1, n);
    check(32'(n > 55 && n < 85), 32'h1, "on raised");
    repeat (15) @(negedge mclk);
    wr(dppt_pkg::ADDR_OFF, 32'h0000_0002);
    wait_lvl(1'b1, n);
    check(32'(n <= 4), 32'h1, "off cut");
    wr(dppt_pkg::ADDR_OFF, 32'h0000_0014);
    wr(dppt_pkg::ADDR_ON, 32'h0000_0001);
    wait_lvl(1'b0, n);
    check(32'(n <= 4), 32'h1, "on cut");
    repeat (10) @(negedge mclk);
    wr(dppt_pkg::ADDR_OFF, 32'h0000_0028);
    meas(1'b0, n);
    check(32'(n > 80 && n < 115), 32'h1, "off raised");
    set_run(1'b0);
    $display("done change");
  endtask : t_change
  // A run-time preset is lost at reset.
  task automatic t_reload;
    logic [31:0] q;
    wr(dppt_pkg::ADDR_ON, 32'h0000_0007);
    rd(dppt_pkg::ADDR_ON, q);
    check(q, 32'h0000_0007, "on written");
    nrst <= 1'b0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    rd(dppt_pkg::ADDR_ON, q);
    check(q, 32'h0000_0003, "on reloaded");
    $display("done reload");
  endtask : t_reload
  task automatic end_sim;
    $display("compared %0d wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // Main sequence.
  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    t_reset;
    for (int s = 0; s < 4; s++) t_endless(2'(s));
    t_limit;
    t_change;
    t_reload;
    end_sim;
  end
  // The tests need about 1000 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    end_sim;
  end
endmodule : tb_dppt_dual_period_block
